/* File: shared/sbdac_regs.svh */
// Constants for the stereo bitstream converter core
`ifndef SBDAC_REGS_SVH
`define SBDAC_REGS_SVH

`define SBDAC_FRAME_CYCLES  256
`define SBDAC_FRAME_W       8
`define SBDAC_OSR           128
`define SBDAC_CIC_ORDER     4
`define SBDAC_CIC_SHIFT     21
`define SBDAC_SCALE_MUL     52
`define SBDAC_SCALE_SHIFT   7
`define SBDAC_FB_SHIFT      15
`define SBDAC_WORD_RESET    32'h0000_0000
`define SBDAC_IRQ_RESET     2'h0
`define SBDAC_FRAME_RESET   8'h00

`endif

/* File: shared/sbdac_pkg.sv */
// Types shared by the bitstream converter core
package sbdac_pkg;

  // Left in the low half, right in the high half
  typedef struct packed {
    logic signed [15:0] right;
    logic signed [15:0] left;
  } sbdac_pair_t;

  typedef struct packed {
    logic wanted;
    logic underrun;
  } sbdac_irq_t;

  typedef enum logic [1:0] {
    SBDAC_OFF = 2'b01,
    SBDAC_RUN = 2'b10
  } sbdac_state_t;

endpackage

/* File: hdl/sbdac_interp.sv */
// Equalizer and CIC interpolator for one channel
`timescale 1ns/10ps
module sbdac_interp #(
  parameter int IN_W       = 16,
  parameter int OUT_W      = 18,
  parameter int ACC_W      = 40,
  parameter int ORDER      = 4,
  parameter int GAIN_SHIFT = 21
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    run,
  input  wire logic                    load,
  input  wire logic                    tick,
  input  wire logic signed [IN_W-1:0]  din,
  output logic signed [OUT_W-1:0]      dout
);
  logic signed [IN_W-1:0]  x1_reg, x1_next, x2_reg, x2_next;
  logic signed [ACC_W-1:0] dly_reg [ORDER];
  logic signed [ACC_W-1:0] dly_next [ORDER];
  logic signed [ACC_W-1:0] integ_reg [ORDER];
  logic signed [ACC_W-1:0] integ_next [ORDER];
  logic signed [ACC_W-1:0] comb_reg, comb_next;
  logic                    stuff_reg, stuff_next;

  always_comb begin
    logic signed [ACC_W-1:0] cv;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] tmp;
    // Taps -1/4, 6/4, -1/4: unity at DC, lifts the droop of the sinc
    cv = ((ACC_W'(x1_reg) <<< 2) + (ACC_W'(x1_reg) <<< 1) - ACC_W'(din) - ACC_W'(x2_reg)) >>> 2;
    acc = stuff_reg ? comb_reg : '0;
    tmp = '0;
    x1_next = load ? din : x1_reg;
    x2_next = load ? x1_reg : x2_reg;
    for (int k = 0; k < ORDER; k++) begin
      // Comb stages at the sample rate
      dly_next[k] = load ? cv : dly_reg[k];
      cv = cv - dly_reg[k];
    end
    comb_next = load ? cv : comb_reg;
    stuff_next = load ? 1'b1 : (tick ? 1'b0 : stuff_reg);
    for (int k = 0; k < ORDER; k++) begin
      // Integrators at 128x, fed one comb value then zeros
      tmp = integ_reg[k];
      integ_next[k] = tick ? tmp + acc : tmp;
      acc = tmp;
    end
    if (!run) begin
      x1_next = '0;
      x2_next = '0;
      comb_next = '0;
      stuff_next = 1'b0;
      for (int k = 0; k < ORDER; k++) begin
        dly_next[k] = '0;
        integ_next[k] = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      x1_reg <= '0;
      x2_reg <= '0;
      comb_reg <= '0;
      stuff_reg <= 1'b0;
      for (int k = 0; k < ORDER; k++) begin
        dly_reg[k] <= '0;
        integ_reg[k] <= '0;
      end
    end else begin
      x1_reg <= x1_next;
      x2_reg <= x2_next;
      comb_reg <= comb_next;
      stuff_reg <= stuff_next;
      for (int k = 0; k < ORDER; k++) begin
        dly_reg[k] <= dly_next[k];
        integ_reg[k] <= integ_next[k];
      end
    end
  end

  // Interpolator gain is 128 cubed, removed by the shift
  assign dout = OUT_W'(integ_reg[ORDER-1] >>> GAIN_SHIFT);
endmodule

/* File: hdl/sbdac_sdm.sv */
// Third-order one-bit sigma-delta modulator for one channel
`timescale 1ns/10ps
module sbdac_sdm #(
  parameter int IN_W        = 18,
  parameter int ACC_W       = 28,
  parameter int SCALE_MUL   = 52,
  parameter int SCALE_SHIFT = 7,
  parameter int FB_SHIFT    = 15
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   run,
  input  wire logic                   tick,
  input  wire logic signed [IN_W-1:0] din,
  output logic                        bit_out
);
  localparam logic signed [ACC_W-1:0] FB_POS = ACC_W'(1) <<< FB_SHIFT;

  logic signed [ACC_W-1:0] i1_reg, i1_next, i2_reg, i2_next, i3_reg, i3_next;
  logic                    bit_reg, bit_next;

  always_comb begin
    logic signed [ACC_W-1:0] u;
    logic signed [ACC_W-1:0] fb;
    // Negated 52/128 scale puts full scale at 38/128 and 90/128 density
    u = -((ACC_W'(din) * ACC_W'(SCALE_MUL)) >>> SCALE_SHIFT);
    fb = bit_reg ? FB_POS : -FB_POS;
    // Three difference nodes feeding three integrators
    i1_next = i1_reg + (u - fb);
    // Eighth gain on the middle stage keeps the loop stable at low quantizer gain
    i2_next = i2_reg + ((i1_reg >>> 3) - fb);
    i3_next = i3_reg + ((i2_reg >>> 2) - fb);
    // One-bit quantizer
    bit_next = ~i3_next[ACC_W-1];
    if (!tick) begin
      i1_next = i1_reg;
      i2_next = i2_reg;
      i3_next = i3_reg;
      bit_next = bit_reg;
    end
    if (!run) begin
      i1_next = '0;
      i2_next = '0;
      i3_next = '0;
      bit_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      i1_reg <= '0;
      i2_reg <= '0;
      i3_reg <= '0;
      bit_reg <= 1'b0;
    end else begin
      i1_reg <= i1_next;
      i2_reg <= i2_next;
      i3_reg <= i3_next;
      bit_reg <= bit_next;
    end
  end

  assign bit_out = bit_reg;
endmodule

/* File: hdl/sbdac_top.sv */
// Stereo bitstream converter core: sample intake, status, two channels
`timescale 1ns/10ps
`include "sbdac_regs.svh"
module sbdac_top #(
  parameter int FRAME_CYCLES = `SBDAC_FRAME_CYCLES,
  parameter int CIC_ORDER    = `SBDAC_CIC_ORDER,
  parameter int CIC_SHIFT    = `SBDAC_CIC_SHIFT
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire sbdac_pkg::sbdac_pair_t SAMPLE_WORD,
  input  wire logic                 SAMPLE_WRITE,
  input  wire logic                 CTRL_ENABLE,
  input  wire logic                 CTRL_SWAP,
  input  wire logic                 STATUS_READ,
  input  wire sbdac_pkg::sbdac_irq_t IRQ_CLEAR,
  input  wire sbdac_pkg::sbdac_irq_t IRQ_ENABLE_SET,
  input  wire sbdac_pkg::sbdac_irq_t IRQ_DISABLE_SET,
  output sbdac_pkg::sbdac_pair_t    SAMPLE_WORD_Q,
  output sbdac_pkg::sbdac_irq_t     IRQ_STATUS,
  output sbdac_pkg::sbdac_irq_t     IRQ_MASK,
  output logic                      IRQ,
  output logic                      DMA_REQ,
  output logic                      CONV_ACTIVE,
  output logic                      LEFT_BITSTREAM_OUT,
  output logic                      LEFT_BITSTREAM_OUT_INV,
  output logic                      RIGHT_BITSTREAM_OUT,
  output logic                      RIGHT_BITSTREAM_OUT_INV
);
  import sbdac_pkg::*;

  localparam int FRAME_W = `SBDAC_FRAME_W;
  localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAME_CYCLES - 1);

  // Control state
  sbdac_state_t        state_reg, state_next;
  logic [FRAME_W-1:0]  frame_reg, frame_next;

  // Sample intake
  sbdac_pair_t         sample_word_reg, sample_word_next;
  sbdac_pair_t         load_word;
  logic                want_reg, want_next;

  // Status and mask
  sbdac_irq_t          irq_status_reg, irq_status_next;
  sbdac_irq_t          irq_mask_reg, irq_mask_next;
  sbdac_irq_t          status_set, status_clr;
  logic                irq_reg, irq_next;

  // Output bits
  logic                left_reg, left_next;
  logic                left_inv_reg, left_inv_next;
  logic                right_reg, right_next;
  logic                right_inv_reg, right_inv_next;

  // Pipeline control
  logic                run;
  logic                load;
  logic                tick;
  logic signed [15:0]  chan_in [2];
  logic signed [17:0]  chan_mid [2];
  logic                chan_bit [2];

  // Swap applies at write time, so the stored word is already swapped
  function automatic sbdac_pair_t sbdac_arrange(input sbdac_pair_t w, input logic swap);
    sbdac_pair_t r;
    r = w;
    if (swap) begin
      r.left = w.right;
      r.right = w.left;
    end
    return r;
  endfunction

  // Run state follows the enable bit
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SBDAC_OFF: begin
        if (CTRL_ENABLE) begin
          state_next = SBDAC_RUN;
        end
      end
      SBDAC_RUN: begin
        if (!CTRL_ENABLE) begin
          state_next = SBDAC_OFF;
        end
      end
      default: begin
        state_next = SBDAC_OFF;
      end
    endcase
  end

  assign run = (state_reg == SBDAC_RUN);

  // One frame is 256 cycles: one sample in, 128 modulator steps out
  always_comb begin
    frame_next = run ? frame_reg + FRAME_W'(1) : `SBDAC_FRAME_RESET;
    if (run && frame_reg == FRAME_LAST) begin
      frame_next = `SBDAC_FRAME_RESET;
    end
  end

  assign load = run && (frame_reg == `SBDAC_FRAME_RESET);
  assign tick = run && frame_reg[0];

  // A write landing on the load cycle goes straight into the pipeline
  always_comb begin
    load_word = SAMPLE_WRITE ? sbdac_arrange(SAMPLE_WORD, CTRL_SWAP) : sample_word_reg;
    sample_word_next = sample_word_reg;
    if (SAMPLE_WRITE) begin
      sample_word_next = sbdac_arrange(SAMPLE_WORD, CTRL_SWAP);
    end
  end

  // Wanted from each load until a word is written
  always_comb begin
    want_next = want_reg;
    if (!run) begin
      want_next = 1'b0;
    end else if (load) begin
      want_next = 1'b1;
    end else if (SAMPLE_WRITE) begin
      want_next = 1'b0;
    end
  end

  // Status events: set wins over every clear in the same cycle
  always_comb begin
    status_set.wanted = load;
    // Still wanted at the next load means 256 cycles passed unserved
    status_set.underrun = load && want_reg && !SAMPLE_WRITE;
    status_clr.wanted = STATUS_READ || IRQ_CLEAR.wanted || SAMPLE_WRITE;
    status_clr.underrun = STATUS_READ || IRQ_CLEAR.underrun;
    irq_status_next = (irq_status_reg & ~status_clr) | status_set;
  end

  // Disable wins if both strobes hit the same bit together
  always_comb begin
    irq_mask_next = (irq_mask_reg | IRQ_ENABLE_SET) & ~IRQ_DISABLE_SET;
    irq_next = |(irq_status_next & irq_mask_next);
  end

  // Two channels, left from the low half
  assign chan_in[0] = load_word.left;
  assign chan_in[1] = load_word.right;

  for (genvar g = 0; g < 2; g++) begin : g_chan
    sbdac_interp #(
      .IN_W       (16),
      .OUT_W      (18),
      .ACC_W      (40),
      .ORDER      (CIC_ORDER),
      .GAIN_SHIFT (CIC_SHIFT)
    ) u_interp (
      .clk   (CLK),
      .reset (RESET),
      .run   (run),
      .load  (load),
      .tick  (tick),
      .din   (chan_in[g]),
      .dout  (chan_mid[g])
    );

    sbdac_sdm #(
      .IN_W        (18),
      .ACC_W       (28),
      .SCALE_MUL   (`SBDAC_SCALE_MUL),
      .SCALE_SHIFT (`SBDAC_SCALE_SHIFT),
      .FB_SHIFT    (`SBDAC_FB_SHIFT)
    ) u_sdm (
      .clk     (CLK),
      .reset   (RESET),
      .run     (run),
      .tick    (tick),
      .din     (chan_mid[g]),
      .bit_out (chan_bit[g])
    );
  end

  // Inverted pins are complements of the true pins, also while stopped
  always_comb begin
    left_next = run && chan_bit[0];
    right_next = run && chan_bit[1];
    left_inv_next = !left_next;
    right_inv_next = !right_next;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= SBDAC_OFF;
      frame_reg <= `SBDAC_FRAME_RESET;
    end else begin
      state_reg <= state_next;
      frame_reg <= frame_next;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sample_word_reg <= `SBDAC_WORD_RESET;
      want_reg <= 1'b0;
    end else begin
      sample_word_reg <= sample_word_next;
      want_reg <= want_next;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_status_reg <= `SBDAC_IRQ_RESET;
      irq_mask_reg <= `SBDAC_IRQ_RESET;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      left_reg <= 1'b0;
      left_inv_reg <= 1'b1;
      right_reg <= 1'b0;
      right_inv_reg <= 1'b1;
    end else begin
      left_reg <= left_next;
      left_inv_reg <= left_inv_next;
      right_reg <= right_next;
      right_inv_reg <= right_inv_next;
    end
  end

  assign SAMPLE_WORD_Q = sample_word_reg;
  assign IRQ_STATUS = irq_status_reg;
  assign IRQ_MASK = irq_mask_reg;
  assign IRQ = irq_reg;
  assign DMA_REQ = want_reg;
  assign CONV_ACTIVE = state_reg[1];
  assign LEFT_BITSTREAM_OUT = left_reg;
  assign LEFT_BITSTREAM_OUT_INV = left_inv_reg;
  assign RIGHT_BITSTREAM_OUT = right_reg;
  assign RIGHT_BITSTREAM_OUT_INV = right_inv_reg;
endmodule

/* File: bench/sbdac_top_properties.sv */
// Port-level assertions for the stereo bitstream converter core
`timescale 1ns/10ps
module sbdac_top_checker #(
  parameter int FRAME_CYCLES = 256
) (
  input wire logic                   CLK,
  input wire logic                   RESET,
  input wire sbdac_pkg::sbdac_pair_t SAMPLE_WORD,
  input wire logic                   SAMPLE_WRITE,
  input wire logic                   CTRL_ENABLE,
  input wire logic                   CTRL_SWAP,
  input wire logic                   STATUS_READ,
  input wire sbdac_pkg::sbdac_irq_t  IRQ_CLEAR,
  input wire sbdac_pkg::sbdac_irq_t  IRQ_ENABLE_SET,
  input wire sbdac_pkg::sbdac_irq_t  IRQ_DISABLE_SET,
  input wire sbdac_pkg::sbdac_pair_t SAMPLE_WORD_Q,
  input wire sbdac_pkg::sbdac_irq_t  IRQ_STATUS,
  input wire sbdac_pkg::sbdac_irq_t  IRQ_MASK,
  input wire logic                   IRQ,
  input wire logic                   DMA_REQ,
  input wire logic                   CONV_ACTIVE,
  input wire logic                   LEFT_BITSTREAM_OUT,
  input wire logic                   LEFT_BITSTREAM_OUT_INV,
  input wire logic                   RIGHT_BITSTREAM_OUT,
  input wire logic                   RIGHT_BITSTREAM_OUT_INV
);
  import sbdac_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // Cycles the request has stood unanswered
  logic [9:0] age_reg;
  logic [9:0] age_next;
  always_comb begin
    age_next = DMA_REQ ? age_reg + 10'h001 : 10'h000;
    if (age_reg == 10'h3ff) age_next = age_reg;
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) age_reg <= 10'h000;
    else age_reg <= age_next;
  end
  a_pins_inverse: assert property ((LEFT_BITSTREAM_OUT_INV == !LEFT_BITSTREAM_OUT) &&
    (RIGHT_BITSTREAM_OUT_INV == !RIGHT_BITSTREAM_OUT)) else $error("inverted pin wrong");
  a_irq_level: assert property (IRQ == |({IRQ_STATUS} & {IRQ_MASK}))
    else $error("irq level wrong");
  a_mask_set: assert property (IRQ_ENABLE_SET.wanted && !IRQ_DISABLE_SET.wanted |=>
    IRQ_MASK.wanted) else $error("mask not set");
  a_mask_clear: assert property (IRQ_DISABLE_SET.underrun |=> !IRQ_MASK.underrun)
    else $error("mask not cleared");
  a_mask_hold: assert property ({IRQ_ENABLE_SET, IRQ_DISABLE_SET} == 4'h0 |=>
    $stable(IRQ_MASK)) else $error("mask moved");
  a_word_store: assert property (SAMPLE_WRITE |=>
    {SAMPLE_WORD_Q} == ($past(CTRL_SWAP) ?
    {$past(SAMPLE_WORD.left), $past(SAMPLE_WORD.right)} : {$past(SAMPLE_WORD)}))
    else $error("stored word wrong");
  a_clear_under: assert property (IRQ_CLEAR.underrun && !DMA_REQ |=>
    !IRQ_STATUS.underrun) else $error("underrun not cleared");
  a_under_sticky: assert property (IRQ_STATUS.underrun && !IRQ_CLEAR.underrun &&
    !STATUS_READ |=> IRQ_STATUS.underrun) else $error("underrun dropped");
  a_under_late: assert property (DMA_REQ && age_reg == FRAME_CYCLES - 1 &&
    CTRL_ENABLE && !SAMPLE_WRITE |=> IRQ_STATUS.underrun) else $error("underrun missing");
  a_start_run: assert property (CTRL_ENABLE && !CONV_ACTIVE |=> CONV_ACTIVE)
    else $error("no start");
  a_start_req: assert property ($rose(CONV_ACTIVE) && !SAMPLE_WRITE |=>
    DMA_REQ && IRQ_STATUS.wanted) else $error("no request");
  a_stop_quiet: assert property (!CTRL_ENABLE [*2] |=> !(CONV_ACTIVE || DMA_REQ ||
    LEFT_BITSTREAM_OUT || RIGHT_BITSTREAM_OUT)) else $error("not quiet");
  c_underrun: cover property ($rose(IRQ_STATUS.underrun));
  c_irq: cover property ($rose(IRQ));
  c_swap: cover property (SAMPLE_WRITE && CTRL_SWAP && CONV_ACTIVE);
endmodule
bind sbdac_top sbdac_top_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
  .CLK(CLK), .RESET(RESET), .SAMPLE_WORD(SAMPLE_WORD), .SAMPLE_WRITE(SAMPLE_WRITE),
  .CTRL_ENABLE(CTRL_ENABLE), .CTRL_SWAP(CTRL_SWAP), .STATUS_READ(STATUS_READ),
  .IRQ_CLEAR(IRQ_CLEAR), .IRQ_ENABLE_SET(IRQ_ENABLE_SET), .IRQ_DISABLE_SET(IRQ_DISABLE_SET),
  .SAMPLE_WORD_Q(SAMPLE_WORD_Q), .IRQ_STATUS(IRQ_STATUS), .IRQ_MASK(IRQ_MASK), .IRQ(IRQ),
  .DMA_REQ(DMA_REQ), .CONV_ACTIVE(CONV_ACTIVE), .LEFT_BITSTREAM_OUT(LEFT_BITSTREAM_OUT),
  .LEFT_BITSTREAM_OUT_INV(LEFT_BITSTREAM_OUT_INV), .RIGHT_BITSTREAM_OUT(RIGHT_BITSTREAM_OUT),
  .RIGHT_BITSTREAM_OUT_INV(RIGHT_BITSTREAM_OUT_INV));

/* File: bench/sbdac_lpf_model.sv */
// Behavioural differential low-pass load: ones counted per 256-cycle window
`timescale 1ns/10ps
module sbdac_lpf_model (
  input wire logic  clk,
  input wire logic  reset,
  input wire logic  bit_true,
  input wire logic  bit_inv,
  output logic [8:0] ones
);
  logic [7:0] tick_reg;
  logic [8:0] acc_reg;
  // Differential stage: a pin pair that is not complementary adds nothing
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_reg <= 8'h00;
      acc_reg <= 9'h000;
      ones <= 9'h000;
    end else begin
      tick_reg <= tick_reg + 8'h01;
      acc_reg <= (tick_reg == 8'hff) ? 9'h000 : acc_reg + {8'h00, bit_true & ~bit_inv};
      if (tick_reg == 8'hff) ones <= acc_reg + {8'h00, bit_true & ~bit_inv};
    end
  end
endmodule

/* File: bench/stereo_sigma_delta_bitstream_dac_tb_top.sv */
// Self-checking bench for the stereo bitstream converter core
`timescale 1ns/10ps
module stereo_sigma_delta_bitstream_dac_tb_top;
  import sbdac_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  sbdac_pair_t word = 32'h0000_0000;
  sbdac_pair_t word_q;
  logic wr = 1'b0, en = 1'b0, swap = 1'b0, rd = 1'b0;
  logic [1:0] clr = 2'h0, ien = 2'h0, idis = 2'h0, status, mask;
  logic irq, dma_req, active, lo, lo_n, ro, ro_n;
  logic [8:0] ones_l, ones_r;
  sbdac_pair_t exp_q[$];
  sbdac_pair_t lvl[3] = '{32'h8000_7fff, 32'h8000_7fff, 32'h0000_0000};
  int dl[3] = '{76, 180, 128};
  int dr[3] = '{180, 76, 128};
  int seed = 32'ha554cae1;
  int mismatches = 0;
  int num_checks = 0;

  sbdac_top uut (.CLK(clk), .RESET(reset), .SAMPLE_WORD(word), .SAMPLE_WRITE(wr),
    .CTRL_ENABLE(en), .CTRL_SWAP(swap), .STATUS_READ(rd), .IRQ_CLEAR(clr),
    .IRQ_ENABLE_SET(ien), .IRQ_DISABLE_SET(idis), .SAMPLE_WORD_Q(word_q), .IRQ_STATUS(status),
    .IRQ_MASK(mask), .IRQ(irq), .DMA_REQ(dma_req), .CONV_ACTIVE(active),
    .LEFT_BITSTREAM_OUT(lo), .LEFT_BITSTREAM_OUT_INV(lo_n), .RIGHT_BITSTREAM_OUT(ro),
    .RIGHT_BITSTREAM_OUT_INV(ro_n));
  sbdac_lpf_model u_lpf_l (.clk(clk), .reset(reset), .bit_true(lo), .bit_inv(lo_n), .ones(ones_l));
  sbdac_lpf_model u_lpf_r (.clk(clk), .reset(reset), .bit_true(ro), .bit_inv(ro_n), .ones(ones_r));

  // One clock serves bus and conversion, 256 of it per frame
  always #12.5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic near(input logic [8:0] x, input int c);
    return (x >= c - 28) && (x <= c + 28);
  endfunction

  // Note the stored form, pulse the write, then leave an idle cycle
  task automatic put(input sbdac_pair_t w, input logic s);
    word = w;
    swap = s;
    wr = 1'b1;
    exp_q.push_back(s ? {w.left, w.right} : w);
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    while (dma_req !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    check("dma request", 1, dma_req);
  endtask

  always @(posedge clk) begin
    if (wr === 1'b1 && reset === 1'b0) begin
      #1;
      check("stored word", exp_q.pop_front(), word_q);
    end
  end

  initial begin
    #1000000;
    mismatches++;
    stop_test();
  end

  initial begin
    cyc(10);
    reset = 1'b0;
    cyc(1);
    check("idle pins", 32'h5, {lo, lo_n, ro, ro_n});
    check("idle mask", 0, {status, mask});
    $display("test reset done");
    for (int i = 0; i < 8; i++) put(sbdac_pair_t'($random(seed)), i[0]);
    $display("test sample word done");
    ien = 2'h3;
    cyc(1);
    ien = 2'h0;
    cyc(1);
    check("mask set", 3, mask);
    ien = 2'h1;
    idis = 2'h1;
    cyc(1);
    ien = 2'h0;
    idis = 2'h0;
    cyc(5);
    check("disable wins", 2, mask);
    $display("test mask done");
    en = 1'b1;
    wait_req();
    check("ready flag", 2, status);
    check("ready irq", 1, irq);
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    check("read clears", 0, status);
    check("request stays", 1, dma_req);
    ien = 2'h1;
    cyc(1);
    ien = 2'h0;
    cyc(260);
    check("underrun set", 1, status[0]);
    check("underrun irq", 1, irq);
    cyc(300);
    check("underrun held", 1, status[0]);
    // Serve the request first, so no new underrun can meet the clear
    put(lvl[2], 1'b0);
    clr = 2'h1;
    cyc(1);
    clr = 2'h0;
    check("underrun cleared", 0, status[0]);
    check("request dropped", 0, dma_req);
    $display("test status done");
    for (int k = 0; k < 3; k++) begin
      for (int f = 0; f < 12; f++) begin
        wait_req();
        put(lvl[k], k == 1);
      end
      check("left density", 1, near(ones_l, dl[k]));
      check("right density", 1, near(ones_r, dr[k]));
    end
    $display("test density done");
    en = 1'b0;
    cyc(3);
    check("stopped pins", 32'h14, {lo, lo_n, ro, ro_n, active, dma_req});
    $display("test disable done");
    stop_test();
  end
endmodule
